/* File: rtl/tfh_consts.svh */
/*
 * Constants of the hop and noise control block: setup offsets,
 * field positions, reset values and timing counts.
 * Assumes a 250 MHz clock.
 */
`ifndef TFH_CONSTS_SVH
`define TFH_CONSTS_SVH

// ************************************************************
// Setup offsets
// ************************************************************
`define TFH_OFS_SECOND_IDLE  8'hf6
`define TFH_OFS_THIRD_IDLE   8'hf7
`define TFH_OFS_NOISE        8'hf8
`define TFH_OFS_CSUM_LO      8'hf9
`define TFH_OFS_CSUM_HI      8'hfa
`define TFH_OFS_LAST_COVERED 8'hf8

// ************************************************************
// Fields and reset values
// ************************************************************
`define TFH_NOISE_THR_LSB    0
`define TFH_NOISE_LIM_LSB    4
`define TFH_RST_SECOND_IDLE  8'h06
`define TFH_RST_THIRD_IDLE   8'h3f
`define TFH_RST_NOISE        8'h32
`define TFH_RST_CSUM         16'h0000
`define TFH_THR_BASE         8'h05
`define TFH_THR_STEP         8'h03

// Checksum generator, arbitrary choice
`define TFH_CRC_POLY         16'h1021
`define TFH_CRC_INIT         16'hffff

// ************************************************************
// Timing
// ************************************************************
`define TFH_CLK_MHZ          250
`define TFH_PRD_MS           1000
`define TFH_PRD_CYCLES       (`TFH_PRD_MS * 1000 * `TFH_CLK_MHZ)
`define TFH_KEYS             24

`endif

/* File: rtl/tfh_pkg.sv */
/*
 * Types of the hop and noise control block.
 * Assumes the constants header is in the include path.
 */
package tfh_pkg;
	typedef enum logic [1:0] {
		TFH_HOP_OFF,
		TFH_HOP_RECAL,
		TFH_HOP_ADJUST,
		TFH_HOP_SWEEP
	} tfh_hop_mode_t;

	typedef logic [8:0] tfh_idle_t;
	typedef logic [23:0] tfh_keys_t;
endpackage

/* File: rtl/tfh_crc_if.sv */
/*
 * Byte stream from the setup scanner to the checksum engine.
 * Assumes one clock domain.
 */
`timescale 1ns/100ps
interface tfh_crc_if;
	logic        start;
	logic        byte_valid;
	logic [7:0]  byte_data;
	logic [15:0] result;

	modport scan (output start, output byte_valid, output byte_data,
		input result);
	modport engine (input start, input byte_valid, input byte_data,
		output result);
endinterface

/* File: rtl/tfh_crc.sv */
/*
 * Checksum engine: one byte per cycle, MSB first.
 * Assumes start precedes the first byte of each pass.
 */
`timescale 1ns/100ps
`include "tfh_consts.svh"
module tfh_crc (
	input wire logic clk,   // Core clock
	input wire logic reset, // Sync reset, active high
	tfh_crc_if.engine crc   // Byte stream in, result out
);
	import tfh_pkg::*;

	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ({r[14:0], 1'b0} ^ `TFH_CRC_POLY)
				: {r[14:0], 1'b0};
		end
		return r;
	endfunction

	always_ff @(posedge clk) begin
		if (reset || crc.start) begin
			crc.result <= `TFH_CRC_INIT;
		end else if (crc.byte_valid) begin
			crc.result <= crc_byte(crc.result, crc.byte_data);
		end
	end
endmodule

/* File: rtl/tfh_ctrl.sv */
/*
 * Frequency hop, noise integration, setup checksum check and the
 * positive recalibration timer of a capacitive key matrix sensor.
 * Assumes the setup bytes below 0xf6 live in an outside memory with
 * one-cycle read latency, and scan events come from the matrix logic.
 */
`timescale 1ns/100ps
`include "tfh_consts.svh"

module tfh_ctrl #(
	parameter int unsigned PRD_CYCLES = `TFH_PRD_CYCLES
) (
	input  wire logic                  clk,            // Core clock
	input  wire logic                  reset,          // Sync, active high
	input  wire logic                  wr_en,          // Setup write strobe
	input  wire logic [7:0]            wr_addr,        // Setup write address
	input  wire logic [7:0]            wr_data,        // Setup write data
	input  wire logic                  rd_en,          // Setup read strobe
	input  wire logic [7:0]            rd_addr,        // Setup read address
	output logic      [7:0]            rd_data,        // Read data, next cycle
	output logic                       rd_hit,         // Address was ours
	output logic      [7:0]            blk_addr,       // Outside setup address
	input  wire logic [7:0]            blk_data,       // Outside setup byte
	input  wire tfh_pkg::tfh_hop_mode_t hop_mode,      // Hop mode field
	input  wire logic [7:0]            first_idle_time, // First idle setting
	input  wire logic                  cal_busy,       // Calibration running
	input  wire logic                  delta_valid,    // Key delta strobe
	input  wire logic signed [15:0]    delta,          // Key signal delta
	input  wire logic                  scan_done,      // Matrix scan ended
	input  wire tfh_pkg::tfh_keys_t    above_pos_thr,  // Per key over level
	output tfh_pkg::tfh_idle_t         idle_time,      // Burst idle cycles
	output logic      [1:0]            freq_index,     // Active frequency
	output logic                       hop_event,      // Frequency hop pulse
	output logic                       hop_recal_all,  // Hop needs recal
	output logic                       hop_adjust_ref, // Hop adjusts refs
	output logic                       csum_error,     // Checksum mismatch
	output tfh_pkg::tfh_keys_t         key_recal       // Per key recal pulse
);
	import tfh_pkg::*;

	// ************************************************************
	// Decoders
	// ************************************************************
	function automatic tfh_idle_t idle_decode(input logic [7:0] v);
		return (v == 8'h00) ? 9'h100 : {1'b0, v};
	endfunction

	function automatic logic [7:0] thr_decode(input logic [3:0] idx);
		return 8'(`TFH_THR_BASE + `TFH_THR_STEP * idx);
	endfunction

	function automatic logic hop_three(input tfh_hop_mode_t m);
		return (m == TFH_HOP_RECAL) || (m == TFH_HOP_ADJUST);
	endfunction

	// ************************************************************
	// Setup registers
	// ************************************************************
	logic [7:0]  second_burst_idle_time;
	logic [7:0]  third_burst_idle_time;
	logic [7:0]  noise_limit_and_threshold;
	logic [15:0] setup_block_checksum;
	logic [3:0]  noise_threshold;
	logic [3:0]  noise_integrator_limit;

	assign noise_threshold = noise_limit_and_threshold[
		`TFH_NOISE_THR_LSB +: 4];
	assign noise_integrator_limit = noise_limit_and_threshold[
		`TFH_NOISE_LIM_LSB +: 4];

	always_ff @(posedge clk) begin
		if (reset) begin
			second_burst_idle_time    <= `TFH_RST_SECOND_IDLE;
			third_burst_idle_time     <= `TFH_RST_THIRD_IDLE;
			noise_limit_and_threshold <= `TFH_RST_NOISE;
			setup_block_checksum      <= `TFH_RST_CSUM;
		end else if (wr_en) begin
			case (wr_addr)
				`TFH_OFS_SECOND_IDLE: begin
					second_burst_idle_time <= wr_data;
				end
				`TFH_OFS_THIRD_IDLE: begin
					third_burst_idle_time <= wr_data;
				end
				`TFH_OFS_NOISE: begin
					noise_limit_and_threshold <= wr_data;
				end
				`TFH_OFS_CSUM_LO: begin
					setup_block_checksum[7:0] <= wr_data;
				end
				`TFH_OFS_CSUM_HI: begin
					setup_block_checksum[15:8] <= wr_data;
				end
				default: begin
				end
			endcase
		end
	end

	// Other addresses belong to the outside setup memory
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_data <= 8'h00;
			rd_hit  <= 1'b0;
		end else if (rd_en) begin
			rd_hit <= 1'b1;
			case (rd_addr)
				`TFH_OFS_SECOND_IDLE: rd_data <= second_burst_idle_time;
				`TFH_OFS_THIRD_IDLE:  rd_data <= third_burst_idle_time;
				`TFH_OFS_NOISE:       rd_data <= noise_limit_and_threshold;
				`TFH_OFS_CSUM_LO:     rd_data <= setup_block_checksum[7:0];
				`TFH_OFS_CSUM_HI:     rd_data <= setup_block_checksum[15:8];
				default: begin
					rd_data <= 8'h00;
					rd_hit  <= 1'b0;
				end
			endcase
		end else begin
			rd_hit <= 1'b0;
		end
	end

	// ************************************************************
	// Noise integrators
	// ************************************************************
	logic [7:0]  pos_noise;
	logic [7:0]  neg_noise;
	logic [7:0]  thr_counts;
	logic [16:0] neg_mag;
	logic        pos_hit;
	logic        neg_hit;
	logic        noise_hop;

	assign thr_counts = thr_decode(noise_threshold);
	assign neg_mag    = 17'(-(17'(delta)));
	// Gated off in modes 0 and 3
	assign pos_hit = delta_valid && hop_three(hop_mode)
		&& !delta[15] && (delta >= 16'(thr_counts));
	assign neg_hit = delta_valid && hop_three(hop_mode)
		&& delta[15] && (neg_mag >= 17'(thr_counts));
	// Both must reach the limit
	assign noise_hop = hop_three(hop_mode)
		&& (pos_noise >= 8'(noise_integrator_limit))
		&& (neg_noise >= 8'(noise_integrator_limit));

	// Saturate rather than wrap so a noisy scan cannot look quiet
	always_ff @(posedge clk) begin
		if (reset || scan_done) begin
			pos_noise <= 8'h00;
		end else if (pos_hit && pos_noise != 8'hff) begin
			pos_noise <= pos_noise + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (reset || scan_done) begin
			neg_noise <= 8'h00;
		end else if (neg_hit && neg_noise != 8'hff) begin
			neg_noise <= neg_noise + 8'h01;
		end
	end

	// ************************************************************
	// Frequency selection
	// ************************************************************
	logic      hop_now;
	tfh_idle_t sweep_idle;
	tfh_idle_t next_idle;
	tfh_idle_t lo_bound;
	tfh_idle_t hi_bound;

	assign hop_now  = scan_done && noise_hop && !cal_busy;
	assign lo_bound = idle_decode(first_idle_time);
	assign hi_bound = idle_decode(second_burst_idle_time);

	// One step per scan, wrapping back to the shortest idle time
	always_ff @(posedge clk) begin
		if (reset) begin
			sweep_idle <= 9'h001;
		end else if (hop_mode != TFH_HOP_SWEEP) begin
			sweep_idle <= lo_bound;
		end else if (scan_done) begin
			if (sweep_idle >= hi_bound || sweep_idle < lo_bound) begin
				sweep_idle <= lo_bound;
			end else begin
				sweep_idle <= sweep_idle + 9'h001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset || !hop_three(hop_mode)) begin
			freq_index <= 2'd0;
		end else if (hop_now) begin
			freq_index <= (freq_index == 2'd2) ? 2'd0
				: freq_index + 2'd1;
		end
	end

	always_comb begin
		case (hop_mode)
			TFH_HOP_OFF: begin
				next_idle = lo_bound;
			end
			TFH_HOP_RECAL, TFH_HOP_ADJUST: begin
				case (freq_index)
					2'd1: next_idle = hi_bound;
					2'd2: next_idle = idle_decode(
						third_burst_idle_time);
					default: next_idle = lo_bound;
				endcase
			end
			TFH_HOP_SWEEP: begin
				next_idle = sweep_idle;
			end
			default: begin
				next_idle = lo_bound;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			idle_time <= 9'h001;
		end else begin
			idle_time <= next_idle;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			hop_event      <= 1'b0;
			hop_recal_all  <= 1'b0;
			hop_adjust_ref <= 1'b0;
		end else begin
			hop_event      <= hop_now;
			hop_recal_all  <= hop_now && hop_mode == TFH_HOP_RECAL;
			hop_adjust_ref <= hop_now && hop_mode == TFH_HOP_ADJUST;
		end
	end

	// ************************************************************
	// Setup checksum check
	// ************************************************************
	tfh_crc_if crc_bus ();

	logic [7:0] scan_addr;
	logic       scan_valid;
	logic       scan_start;
	logic [7:0] own_byte;

	tfh_crc u_crc (
		.clk   (clk),
		.reset (reset),
		.crc   (crc_bus.engine)
	);

	// Own bytes are fed locally, the rest from the outside memory
	always_comb begin
		case (scan_addr)
			`TFH_OFS_SECOND_IDLE: own_byte = second_burst_idle_time;
			`TFH_OFS_THIRD_IDLE:  own_byte = third_burst_idle_time;
			`TFH_OFS_NOISE:       own_byte = noise_limit_and_threshold;
			default:              own_byte = blk_data;
		endcase
	end

	assign crc_bus.start      = scan_start;
	assign crc_bus.byte_valid = scan_valid;
	assign crc_bus.byte_data  = own_byte;

	// Address leads data by one cycle for the outside memory
	always_ff @(posedge clk) begin
		if (reset) begin
			blk_addr   <= 8'h00;
			scan_addr  <= 8'h00;
			scan_valid <= 1'b0;
			scan_start <= 1'b1;
		end else begin
			scan_start <= 1'b0;
			scan_addr  <= blk_addr;
			if (scan_start) begin
				scan_valid <= 1'b1;
				blk_addr   <= blk_addr + 8'h01;
			end else if (scan_addr == `TFH_OFS_LAST_COVERED) begin
				scan_valid <= 1'b0;
				scan_start <= 1'b1;
				blk_addr   <= 8'h00;
			end else begin
				blk_addr <= (blk_addr == `TFH_OFS_LAST_COVERED)
					? blk_addr : blk_addr + 8'h01;
			end
		end
	end

	logic pass_end;
	assign pass_end = scan_valid && scan_addr == `TFH_OFS_LAST_COVERED;

	logic pass_end_d;
	always_ff @(posedge clk) begin
		if (reset) begin
			pass_end_d <= 1'b0;
			csum_error <= 1'b0;
		end else begin
			pass_end_d <= pass_end;
			if (pass_end_d) begin
				csum_error <= crc_bus.result
					!= setup_block_checksum;
			end
		end
	end

	// ************************************************************
	// Positive recalibration timers
	// ************************************************************
	// Full delay width; simulations shorten it through PRD_CYCLES
	genvar k;
	generate
		for (k = 0; k < `TFH_KEYS; k++) begin : g_prd
			logic [31:0] held;
			always_ff @(posedge clk) begin
				if (reset || !above_pos_thr[k]) begin
					held         <= 32'h0;
					key_recal[k] <= 1'b0;
				end else if (held == PRD_CYCLES - 1) begin
					held         <= 32'h0;
					key_recal[k] <= 1'b1;
				end else begin
					held         <= held + 32'h1;
					key_recal[k] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule

/* File: verif/tfh_setup_mem.sv */
/* Setup memory model standing for the host's copy of the setup bytes.
   Assumes the block reads one byte a cycle with one cycle of latency. */
`timescale 1ns/100ps
module tfh_setup_mem (
	input  wire logic       clk,      // Core clock
	input  wire logic [7:0] blk_addr, // Byte address
	output logic      [7:0] blk_data  // Byte, one cycle later
);
	// Fixed pattern so the bench can work out the checksum itself
	always_ff @(posedge clk) begin
		blk_data <= blk_addr ^ 8'h5a;
	end
endmodule

/* File: verif/tfh_ctrl_properties.sv */
/* Port checker for the hop and noise control block.
   Assumes one clock and a synchronous active high reset. */
`timescale 1ns/100ps
module tfh_ctrl_chk
	import tfh_pkg::*;
#(
	parameter int unsigned PRD_CYCLES = 20
) (
	input wire logic         clk,            // Clock
	input wire logic         reset,          // Reset
	input wire logic         rd_en,          // Read strobe
	input wire logic [7:0]   rd_addr,        // Read address
	input wire logic [7:0]   rd_data,        // Read data
	input wire logic         rd_hit,         // Read hit
	input wire logic [7:0]   blk_addr,       // Setup scan address
	input wire tfh_hop_mode_t hop_mode,      // Hop mode
	input wire logic [7:0]   first_idle_time, // First idle
	input wire logic         cal_busy,       // Calibrating
	input wire logic         scan_done,      // Scan end
	input wire tfh_keys_t    above_pos_thr,  // Key levels
	input wire tfh_idle_t    idle_time,      // Idle in use
	input wire logic [1:0]   freq_index,     // Frequency
	input wire logic         hop_event,      // Hop pulse
	input wire logic         hop_recal_all,  // Recal pulse
	input wire logic         hop_adjust_ref, // Adjust pulse
	input wire tfh_keys_t    key_recal       // Key recal
);
	logic [31:0] run0;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Run length of key 0 over its positive level
	always_ff @(posedge clk) begin
		if (reset || !above_pos_thr[0])
			run0 <= 32'h0;
		else
			run0 <= run0 + 32'h1;
	end

	chk_hop_cause: assert property (
		hop_event |-> $past(scan_done) && !$past(cal_busy) &&
		$past(hop_mode) inside {TFH_HOP_RECAL, TFH_HOP_ADJUST})
		else $error("hop without cause");
	chk_hop_recal: assert property (
		hop_recal_all |-> hop_event && $past(hop_mode) == TFH_HOP_RECAL)
		else $error("recal pulse wrong");
	chk_hop_adjust: assert property (
		hop_adjust_ref |-> hop_event && $past(hop_mode) == TFH_HOP_ADJUST)
		else $error("adjust pulse wrong");
	chk_freq_rotate: assert property (
		hop_event |-> freq_index == (($past(freq_index) == 2'h2) ?
		2'h0 : $past(freq_index) + 2'h1))
		else $error("frequency not rotated");
	chk_freq_idle: assert property (
		hop_mode inside {TFH_HOP_OFF, TFH_HOP_SWEEP} [*2] |->
		freq_index == 2'h0)
		else $error("frequency index not zero");
	chk_idle_range: assert property (
		idle_time != 9'h0 && idle_time <= 9'h100)
		else $error("idle time out of range");
	chk_idle_off: assert property (
		(hop_mode == TFH_HOP_OFF && $stable(first_idle_time)) [*3] |->
		idle_time == ((first_idle_time == 8'h0) ? 9'h100 :
		{1'b0, first_idle_time}))
		else $error("idle time not first setting");
	chk_rd_miss: assert property (
		rd_en && !(rd_addr inside {[8'hf6:8'hfa]}) |=>
		!rd_hit && rd_data == 8'h0)
		else $error("unmapped read answered");
	chk_rd_hit: assert property (
		rd_en && rd_addr inside {[8'hf6:8'hfa]} |=> rd_hit)
		else $error("mapped read missed");
	chk_recal_hold: assert property (
		key_recal[0] |-> run0 >= PRD_CYCLES - 1)
		else $error("key recal too early");
	chk_blk_range: assert property (
		blk_addr <= 8'hf8)
		else $error("scan address past setup block");
endmodule

bind tfh_ctrl tfh_ctrl_chk #(.PRD_CYCLES(PRD_CYCLES)) u_chk (
	.clk(clk), .reset(reset), .rd_en(rd_en), .rd_addr(rd_addr),
	.rd_data(rd_data), .rd_hit(rd_hit), .blk_addr(blk_addr),
	.hop_mode(hop_mode),
	.first_idle_time(first_idle_time), .cal_busy(cal_busy),
	.scan_done(scan_done), .above_pos_thr(above_pos_thr),
	.idle_time(idle_time), .freq_index(freq_index),
	.hop_event(hop_event), .hop_recal_all(hop_recal_all),
	.hop_adjust_ref(hop_adjust_ref), .key_recal(key_recal));

/* File: verif/tfh_ctrl_test.sv */
/* Self-checking bench for the hop and noise control block.
   Assumes the setup memory model and a 250 MHz clock. */
`timescale 1ns/100ps
module tfh_ctrl_test;
	import tfh_pkg::*;
	logic clk, reset, wr_en, rd_en, rd_hit, cal_busy, delta_valid;
	logic scan_done, hop_event, hop_recal_all, hop_adjust_ref;
	logic csum_error;
	logic [7:0] wr_addr, wr_data, rd_addr, rd_data, blk_addr, blk_data;
	logic [7:0] first_idle_time, s1, s2;
	logic signed [15:0] delta;
	logic [1:0] freq_index, fexp;
	tfh_hop_mode_t hop_mode;
	tfh_idle_t idle_time;
	tfh_keys_t above_pos_thr, key_recal;
	int err_total, tests_run;

	tfh_ctrl #(.PRD_CYCLES(20)) dut (.clk(clk), .reset(reset),
		.wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
		.rd_hit(rd_hit), .blk_addr(blk_addr), .blk_data(blk_data),
		.hop_mode(hop_mode), .first_idle_time(first_idle_time),
		.cal_busy(cal_busy), .delta_valid(delta_valid), .delta(delta),
		.scan_done(scan_done), .above_pos_thr(above_pos_thr),
		.idle_time(idle_time), .freq_index(freq_index),
		.hop_event(hop_event), .hop_recal_all(hop_recal_all),
		.hop_adjust_ref(hop_adjust_ref), .csum_error(csum_error),
		.key_recal(key_recal));
	tfh_setup_mem u_mem (.clk(clk), .blk_addr(blk_addr),
		.blk_data(blk_data));

	// ****************
	// Helpers
	// ****************
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, d, input logic h);
		@(posedge clk);
		rd_en <= 1'b1;
		rd_addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk("rd_data", 16'(rd_data), 16'(d));
		chk("rd_hit", 16'(rd_hit), 16'(h));
	endtask

	function automatic tfh_idle_t dec(input logic [7:0] x);
		return (x == 8'h0) ? 9'h100 : {1'b0, x};
	endfunction

	// Deltas of both signs, then a scan end; judge the hop outcome
	task automatic noise(input int p, n, input logic [15:0] v,
		input logic h);
		repeat (p) begin
			@(posedge clk);
			delta_valid <= 1'b1;
			delta <= v;
		end
		repeat (n) begin
			@(posedge clk);
			delta_valid <= 1'b1;
			delta <= -v;
		end
		@(posedge clk);
		delta_valid <= 1'b0;
		scan_done <= 1'b1;
		@(posedge clk);
		scan_done <= 1'b0;
		#1;
		if (h)
			fexp = (fexp == 2'h2) ? 2'h0 : fexp + 2'h1;
		chk("hop", 16'(hop_event), 16'(h));
		chk("recal", 16'(hop_recal_all),
			16'(h && hop_mode == TFH_HOP_RECAL));
		chk("adjust", 16'(hop_adjust_ref),
			16'(h && hop_mode == TFH_HOP_ADJUST));
		chk("freq", 16'(freq_index), 16'(fexp));
		@(posedge clk);
		#1;
		if (hop_mode != TFH_HOP_SWEEP)
			chk("idle", 16'(idle_time), 16'((fexp == 2'h0) ?
				dec(first_idle_time) : dec((fexp == 2'h1) ? s1 : s2)));
	endtask

	function automatic logic [15:0] crc_exp();
		logic [15:0] c;
		c = 16'hffff;
		for (int a = 0; a <= 248; a++) begin
			c = c ^ {8'(a) ^ 8'h5a, 8'h00};
			for (int b = 0; b < 8; b++)
				c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
		end
		return c;
	endfunction

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset_vals;
		rd(8'hf6, 8'h06, 1'b1);
		rd(8'hf7, 8'h3f, 1'b1);
		rd(8'hf8, 8'h32, 1'b1);
		rd(8'hf9, 8'h00, 1'b1);
		rd(8'hf5, 8'h00, 1'b0);
	endtask

	task automatic t_hop_basic;
		@(posedge clk) hop_mode <= TFH_HOP_RECAL;
		noise(3, 3, 16'd11, 1'b1);
		noise(3, 3, 16'd11, 1'b1);
		noise(3, 3, 16'd10, 1'b0);
		noise(3, 2, 16'd11, 1'b0);
		noise(3, 0, 16'd11, 1'b0);
		noise(0, 3, 16'd11, 1'b0);
		@(posedge clk) cal_busy <= 1'b1;
		noise(3, 3, 16'd11, 1'b0);
		@(posedge clk) cal_busy <= 1'b0;
		hop_mode <= TFH_HOP_ADJUST;
		noise(3, 3, 16'd11, 1'b1);
	endtask

	task automatic t_encode;
		wr(8'hf6, 8'h00);
		s1 = 8'h00;
		wr(8'hf8, 8'h4f);
		noise(3, 3, 16'd50, 1'b0);
		noise(4, 4, 16'd49, 1'b0);
		noise(4, 4, 16'd50, 1'b1);
		@(posedge clk) hop_mode <= TFH_HOP_SWEEP;
		fexp = 2'h0;
		noise(4, 4, 16'd50, 1'b0);
		@(posedge clk) hop_mode <= TFH_HOP_OFF;
		noise(4, 4, 16'd50, 1'b0);
	endtask

	// Sweep steps one idle cycle per scan between the two bounds
	task automatic t_sweep;
		tfh_idle_t e;
		e = dec(first_idle_time);
		wr(8'hf6, 8'h12);
		s1 = 8'h12;
		@(posedge clk) hop_mode <= TFH_HOP_SWEEP;
		repeat (4) begin
			@(posedge clk);
			scan_done <= 1'b1;
			@(posedge clk);
			scan_done <= 1'b0;
			@(posedge clk);
			#1;
			e = (e >= dec(s1)) ? dec(first_idle_time) : e + 9'h001;
			chk("sweep", 16'(idle_time), 16'(e));
		end
	endtask

	task automatic t_csum;
		logic [15:0] c;
		c = crc_exp();
		wr(8'hf6, 8'hac);
		wr(8'hf7, 8'had);
		wr(8'hf8, 8'ha2);
		wr(8'hf9, c[7:0] ^ 8'h01);
		wr(8'hfa, c[15:8]);
		repeat (600) @(posedge clk);
		#1;
		chk("csum_bad", 16'(csum_error), 16'h1);
		wr(8'hf9, c[7:0]);
		rd(8'hfa, c[15:8], 1'b1);
		repeat (600) @(posedge clk);
		#1;
		chk("csum_ok", 16'(csum_error), 16'h0);
	endtask

	task automatic t_recal;
		int cnt;
		cnt = 0;
		@(posedge clk);
		above_pos_thr <= 24'h800001;
		while (key_recal[0] !== 1'b1 && cnt < 40) begin
			@(posedge clk);
			#1;
			cnt++;
		end
		chk("recal_t", 16'(cnt >= 19 && cnt <= 22), 16'h1);
		chk("recal_k", key_recal[15:0], 16'h0001);
		chk("recal_hi", 16'(key_recal[23:16]), 16'h0080);
		@(posedge clk) above_pos_thr <= 24'h000000;
	endtask

	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ****************
	// Run
	// ****************
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		stop_test();
	end

	initial begin
		{wr_en, rd_en, cal_busy, delta_valid, scan_done} = 5'h0;
		{wr_addr, wr_data, rd_addr} = 24'h0;
		delta = 16'h0;
		above_pos_thr = 24'h0;
		hop_mode = TFH_HOP_OFF;
		first_idle_time = 8'h10;
		s1 = 8'h06;
		s2 = 8'h3f;
		fexp = 2'h0;
		err_total = 0;
		tests_run = 0;
		reset = 1'b1;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		t_reset_vals();
		t_hop_basic();
		t_encode();
		t_sweep();
		t_csum();
		t_recal();
		stop_test();
	end
endmodule
